// >>> common/pmcrs_pkg.sv
// Purpose: Constants for the power-module command register set.
// Assumes: Linear words carry a 5-bit exponent in [15:11] and an 11-bit mantissa.
// Notes:   Output voltage words are plain 16-bit mantissas with exponent -12.
package pmcrs_pkg;
	// Command codes
	localparam logic [7:0] CMD_OPERATION   = 8'h01;
	localparam logic [7:0] CMD_CLEAR_FLT   = 8'h03;
	localparam logic [7:0] CMD_STORE_ALL   = 8'h11;
	localparam logic [7:0] CMD_OTW_LIMIT   = 8'h51;
	localparam logic [7:0] CMD_VIN_OV      = 8'h55;
	localparam logic [7:0] CMD_GOOD_ON     = 8'h5e;
	localparam logic [7:0] CMD_GOOD_OFF    = 8'h5f;
	localparam logic [7:0] CMD_TURN_ON_DELAY   = 8'h60;
	localparam logic [7:0] CMD_OUTPUT_RISE_TIME    = 8'h61;
	localparam logic [7:0] CMD_STAT_SUM    = 8'h79;
	localparam logic [7:0] CMD_STAT_VOUT   = 8'h7a;
	localparam logic [7:0] CMD_STAT_IOUT   = 8'h7b;
	localparam logic [7:0] CMD_STAT_INPUT  = 8'h7c;
	localparam logic [7:0] CMD_STAT_TEMP   = 8'h7d;
	localparam logic [7:0] CMD_STAT_COMM   = 8'h7e;
	localparam logic [7:0] CMD_READ_VIN    = 8'h88;
	localparam logic [7:0] CMD_READ_VOUT   = 8'h8b;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_READING   = 8'h8c;
	localparam logic [7:0] CMD_READ_TEMP   = 8'h8d;
	localparam logic [7:0] CMD_PROTO_REV   = 8'h98;
	localparam logic [7:0] CMD_AUX_FUNC    = 8'he0;
	localparam logic [7:0] CMD_AUX_POL     = 8'he1;
	localparam logic [7:0] CMD_GOOD_POL    = 8'he2;
	localparam logic [7:0] CMD_FLASH_KEY   = 8'hec;
	// Values after reset, and the flash unlock key
	localparam logic [7:0]  RST_OPERATION  = 8'h80;
	localparam logic [15:0] RST_OTW_LIMIT  = 16'hf190; // 100 C, exp -2
	localparam logic [15:0] RST_VIN_OV     = 16'he9f0; // 62 V, exp -3
	localparam logic [15:0] RST_GOOD_ON    = 16'hb666; // 11.4 V, exp -12
	localparam logic [15:0] RST_GOOD_OFF   = 16'hb333; // 11.2 V, exp -12
	localparam logic [15:0] RST_TURN_ON_DELAY  = 16'hf84e; // 39 ms, exp -1
	localparam logic [15:0] RST_OUTPUT_RISE_TIME   = 16'hf82c; // 22 ms, exp -1
	localparam logic [7:0]  RST_AUX_FUNC   = 8'h00;
	localparam logic [7:0]  RST_AUX_POL    = 8'h00;
	localparam logic [7:0]  RST_GOOD_POL   = 8'h01;
	localparam logic [31:0] RST_FLASH_KEY  = 32'ha5a5a5a5;
	localparam logic [31:0] UNLOCK_KEY     = 32'h7e15dc42; // First byte sent in [31:24]
	// Exponent fields and accepted mantissa ranges
	localparam logic [4:0]  EXP_M1         = 5'h1f;
	localparam logic [4:0]  EXP_M2         = 5'h1e;
	localparam logic [10:0] OTW_MIN        = 11'h140; // 80 C
	localparam logic [10:0] OTW_MAX        = 11'h1e0; // 120 C
	localparam logic [10:0] TURN_ON_DELAY_MIN  = 11'h046; // 35 ms
	localparam logic [10:0] TURN_ON_DELAY_MAX  = 11'h3e8; // 500 ms
	localparam logic [10:0] OUTPUT_RISE_TIME_MIN   = 11'h01e; // 15 ms
	localparam logic [10:0] OUTPUT_RISE_TIME_MAX   = 11'h032; // 25 ms
	// Status bit positions
	localparam int          BIT_FAULT      = 7;
	localparam int          BIT_WARN_V     = 6;
	localparam int          BIT_WARN_I     = 5;
	localparam int          BIT_IN_UV      = 4;
	localparam int          BIT_CML_CMD    = 7;
	localparam int          BIT_CML_DATA   = 6;
	// Timing: one step of the turn-on timers is 0.5 ms, the LSB of an exponent -1 time word
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          STEP_NS        = 500000;
	localparam int          STEP_CYC       = STEP_NS / CLK_PERIOD_NS;
endpackage : pmcrs_pkg

// >>> sim/pmcrs_host.sv
// Purpose: Host side of the command port, one command per call.
// Assumes: Command is taken at the edge where cmd_valid_o is high.
// Notes:   Released code and data lines show the inverse, never the last value.
`timescale 1ns/1ps
`default_nettype none
module pmcrs_host (
	input  wire logic        ref_clk_i,
	input  wire logic        rsp_valid_i,
	input  wire logic [31:0] rsp_rdata_i,
	output logic             cmd_valid_o,
	output logic             cmd_write_o,
	output logic [7:0]       cmd_code_o,
	output logic [31:0]      cmd_wdata_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_code_o  = 8'h00;
		cmd_wdata_o = 32'h0;
	end
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [31:0] data,
			output logic [31:0] rdata, output logic ok);
		int n;
		@(posedge ref_clk_i);
		cmd_valid_o <= 1'b1;
		cmd_write_o <= wr;
		cmd_code_o  <= code;
		cmd_wdata_o <= data;
		@(posedge ref_clk_i);
		cmd_valid_o <= 1'b0;
		cmd_code_o  <= ~code;
		cmd_wdata_o <= ~data;
		ok = 1'b0;
		rdata = 32'h0;
		for (n = 0; n < 4 && !ok; n++) begin
			#1;
			if (rsp_valid_i === 1'b1) begin
				ok = 1'b1;
				rdata = rsp_rdata_i;
			end else
				@(posedge ref_clk_i);
		end
	endtask : xfer
	// Key bytes go first byte in [31:24]
	task automatic unlock(output logic ok);
		logic [31:0] r;
		xfer(1'b1, 8'hec, 32'h7e15dc42, r, ok);
	endtask : unlock
endmodule : pmcrs_host
`default_nettype wire

// >>> sim/pmcrs_top_bench.sv
// Purpose: Self-checking bench of the command register set.
// Assumes: Clock enable high but for one freeze check; host model drives the command port.
// Notes:   Turn-on run uses the shortest delay and rise and a 100-cycle step to stay brief.
`timescale 1ns/1ps
`default_nettype none
module pmcrs_top_bench;
	logic        ce, ref_clk_i, reset_n_i, cmd_valid, cmd_write, input_valid, rsp_valid;
	logic        good, aux, rising, regulated, store;
	logic [7:0]  cmd_code;
	logic [31:0] cmd_wdata, rsp_rdata;
	logic [15:0] vin, vout, iout, temp;
	logic [6:0]  flt;
	int          errors, checked, stores;
	pmcrs_top #(.PROTO_REV(8'h3c), .STEP_CYC(100)) i_pmcrs_top (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .cmd_valid_i(cmd_valid),
		.cmd_write_i(cmd_write), .cmd_code_i(cmd_code),
		.cmd_wdata_i(cmd_wdata), .vin_reading_i(vin), .vout_reading_i(vout),
		.iout_reading_i(iout), .temp_reading_i(temp), .input_valid_i(input_valid),
		.vout_ov_fault_i(flt[0]), .vout_ov_warn_i(flt[1]), .iout_oc_fault_i(flt[2]),
		.iout_oc_warn_i(flt[3]), .vin_ov_fault_i(flt[4]), .vin_uv_fault_i(flt[5]),
		.ot_fault_i(flt[6]), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata),
		.good_output_signal_o(good), .aux_configurable_pin_o(aux),
		.output_rising_o(rising), .output_regulated_o(regulated), .flash_store_o(store));
	pmcrs_host i_pmcrs_host (.ref_clk_i(ref_clk_i), .rsp_valid_i(rsp_valid),
		.rsp_rdata_i(rsp_rdata), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
		.cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata));
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) if (store === 1'b1) stores++;
	task automatic print_verdict;
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic lost(input logic ok);
		if (!ok) begin
			errors++;
			$display("[FAIL] %0t no answer", $time);
			print_verdict();
		end
	endtask : lost
	task automatic rd(input logic [7:0] code, input logic [31:0] exp);
		logic [31:0] r;
		logic        ok;
		i_pmcrs_host.xfer(1'b0, code, 32'h0, r, ok);
		lost(ok);
		chk(r, exp);
	endtask : rd
	task automatic wr(input logic [7:0] code, input logic [31:0] data);
		logic [31:0] r;
		logic        ok;
		i_pmcrs_host.xfer(1'b1, code, data, r, ok);
		lost(ok);
	endtask : wr
	task automatic t_defaults;
		rd(8'h51, 32'hf190);
		rd(8'h55, 32'he9f0);
		rd(8'h5e, 32'hb666);
		rd(8'h5f, 32'hb333);
		rd(8'h60, 32'hf84e);
		rd(8'h61, 32'hf82c);
		rd(8'h98, 32'h3c);
		rd(8'he0, 32'h00);
		rd(8'he1, 32'h00);
		rd(8'he2, 32'h01);
		rd(8'hec, 32'ha5a5a5a5);
		rd(8'h01, 32'h80);
	endtask : t_defaults
	task automatic t_limits;
		wr(8'h51, 32'hf140);
		rd(8'h51, 32'hf140);
		wr(8'h51, 32'hf1e4);
		rd(8'h51, 32'hf140);
		wr(8'h60, 32'hfbe8);
		wr(8'h60, 32'hfbe9);
		rd(8'h60, 32'hfbe8);
		wr(8'h61, 32'hf81e);
		wr(8'h61, 32'hf81d);
		wr(8'h61, 32'hf01e);
		rd(8'h61, 32'hf81e);
		rd(8'h7e, 32'h40);
		wr(8'h03, 32'h0);
		wr(8'h55, 32'h1234);
		wr(8'h5e, 32'h0);
		rd(8'h20, 32'h00);
		rd(8'h55, 32'he9f0);
		rd(8'h5e, 32'hb666);
		rd(8'h7e, 32'h80);
		wr(8'h03, 32'h0);
		rd(8'h7e, 32'h00);
	endtask : t_limits
	task automatic t_status;
		@(posedge ref_clk_i);
		ce <= 1'b0;
		vin <= 16'he9b0;
		vout <= 16'h0123;
		iout <= 16'hd23c;
		temp <= 16'hf1e0;
		flt <= 7'h7f;
		@(posedge ref_clk_i);
		ce <= 1'b1;
		flt <= 7'h00;
		rd(8'h7a, 32'h00);
		flt <= 7'h7f;
		repeat (2) @(posedge ref_clk_i);
		flt <= 7'h00;
		rd(8'h88, 32'he9b0);
		rd(8'h8b, 32'h0123);
		rd(8'h8c, 32'hd23c);
		rd(8'h8d, 32'hf1e0);
		rd(8'h7a, 32'hc0);
		rd(8'h7b, 32'ha0);
		rd(8'h7c, 32'h90);
		rd(8'h7d, 32'hc0);
		rd(8'h79, 32'he87c);
		temp <= 16'h0;
		flt <= 7'h40;
		wr(8'h03, 32'h0);
		flt <= 7'h00;
		rd(8'h7a, 32'h00);
		rd(8'h7d, 32'h80);
		rd(8'h79, 32'h0844);
	endtask : t_status
	task automatic t_good;
		int i;
		logic [15:0] lvl[4] = '{16'hb665, 16'hb666, 16'hb334, 16'hb333};
		logic        exp[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		for (i = 0; i < 4; i++) begin
			vout <= lvl[i];
			repeat (3) @(posedge ref_clk_i);
			chk(good, exp[i]);
		end
		wr(8'he2, 32'h00);
		repeat (2) @(posedge ref_clk_i);
		chk(good, 1'b1);
		wr(8'he2, 32'h01);
	endtask : t_good
	task automatic t_turn_on;
		int n;
		wr(8'h60, 32'hf846);
		wr(8'he0, 32'h01);
		@(posedge ref_clk_i);
		input_valid <= 1'b1;
		// 35 ms and 15 ms at 0.5 ms per 100-cycle step
		for (n = 0; n < 8000 && rising !== 1'b1; n++) @(posedge ref_clk_i);
		lost(rising === 1'b1);
		chk(n >= 6990 && n <= 7010, 1'b1);
		for (n = 0; n < 4000 && regulated !== 1'b1; n++) @(posedge ref_clk_i);
		lost(regulated === 1'b1);
		chk(n >= 2990 && n <= 3010, 1'b1);
		repeat (2) @(posedge ref_clk_i);
		chk(aux, 1'b1);
		wr(8'he1, 32'h01);
		repeat (2) @(posedge ref_clk_i);
		chk(aux, 1'b0);
		input_valid <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		chk(regulated, 1'b0);
	endtask : t_turn_on
	task automatic t_flash;
		logic ok;
		wr(8'h11, 32'h0);
		repeat (2) @(posedge ref_clk_i);
		chk(stores, 0);
		rd(8'h7e, 32'h40);
		i_pmcrs_host.unlock(ok);
		lost(ok);
		wr(8'h11, 32'h0);
		repeat (2) @(posedge ref_clk_i);
		chk(stores, 1);
		wr(8'h11, 32'h0);
		repeat (2) @(posedge ref_clk_i);
		chk(stores, 1);
	endtask : t_flash
	initial begin
		errors = 0;
		checked = 0;
		stores = 0;
		reset_n_i = 1'b0;
		input_valid = 1'b0;
		ce = 1'b1;
		flt = 7'h00;
		vin = 16'h0;
		vout = 16'h0;
		iout = 16'h0;
		temp = 16'h0;
		repeat (5) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		t_defaults();
		t_limits();
		t_status();
		t_good();
		t_flash();
		t_turn_on();
		print_verdict();
	end
endmodule : pmcrs_top_bench
`default_nettype wire

// >>> verilog/pmcrs_top.sv
// Purpose: Command register set of a power-module management slave.
// Assumes: Link framing is done outside; one command per cmd_valid_i, all inputs synchronous.
// Notes:   Timer step length comes from the package; rules follow.
// Function
// - Over-temperature warning word at 0x51 reads and writes, default 100, range 80 to 120.
// - Input overvoltage threshold at 0x55 is read-only, default 62 volts.
// - Power good asserts when output voltage reaches the 0x5E threshold.
// - Power good negates when output voltage falls to the 0x5F threshold.
// - Turn-on delay at 0x60 writable, default 39 ms, range 35 to 500.
// - Rise time at 0x61 writable, default 22 ms, range 15 to 25.
// - Summary status word of all faults and warnings at 0x79.
// - Output voltage status byte at 0x7A, output current status at 0x7B.
// - Input status at 0x7C, temperature at 0x7D, communication at 0x7E.
// - Measured input voltage word at 0x88.
// - Measured output voltage word at 0x8B.
// - Measured output current word at 0x8C.
// - Hot-spot temperature word at 0x8D.
// - Protocol revision byte at 0x98.
// - Auxiliary pin function byte at 0xE0, reset 0x00.
// - Power-good polarity byte at 0xE2, reset 0x01 positive.
// - Save-all command accepted only while flash is unlocked.
`timescale 1ns/1ps
`default_nettype none
module pmcrs_top #(
	parameter logic [7:0] PROTO_REV = 8'h11, // Arbitrary revision code
	parameter int         STEP_CYC  = pmcrs_pkg::STEP_CYC
) (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ce_i,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [31:0] cmd_wdata_i,
	input  wire logic [15:0] vin_reading_i,
	input  wire logic [15:0] vout_reading_i,
	input  wire logic [15:0] iout_reading_i,
	input  wire logic [15:0] temp_reading_i,
	input  wire logic        input_valid_i,
	input  wire logic        vout_ov_fault_i,
	input  wire logic        vout_ov_warn_i,
	input  wire logic        iout_oc_fault_i,
	input  wire logic        iout_oc_warn_i,
	input  wire logic        vin_ov_fault_i,
	input  wire logic        vin_uv_fault_i,
	input  wire logic        ot_fault_i,
	output logic             rsp_valid_o,
	output logic [31:0]      rsp_rdata_o,
	output logic             good_output_signal_o,
	output logic             aux_configurable_pin_o,
	output logic             output_rising_o,
	output logic             output_regulated_o,
	output logic             flash_store_o
);
	typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_RISE, SEQ_ON} pmcrs_seq_e;

	// Accepts a linear word only with the expected exponent and a mantissa in range
	function automatic logic lin_ok(input logic [15:0] w, input logic [4:0] e,
			input logic [10:0] lo, input logic [10:0] hi);
		lin_ok = (w[15:11] == e) && (w[10:0] >= lo) && (w[10:0] <= hi);
	endfunction : lin_ok

	logic [7:0]  operation_ff;
	logic [15:0] otw_limit_ff;
	logic [15:0] turn_on_delay_ff;
	logic [15:0] output_rise_time_ff;
	logic [7:0]  aux_func_ff;
	logic [7:0]  aux_pol_ff;
	logic [7:0]  good_pol_ff;
	logic [31:0] flash_key_ff;
	logic [7:0]  st_vout_ff;
	logic [7:0]  st_iout_ff;
	logic [7:0]  st_input_ff;
	logic [7:0]  st_temp_ff;
	logic [7:0]  st_cml_ff;
	logic        pg_ff;
	pmcrs_seq_e  seq_ff;
	pmcrs_seq_e  nxt_seq;
	logic [$clog2(STEP_CYC)-1:0] step_cnt_ff;
	logic [10:0] step_num_ff;
	logic        rsp_valid_ff;
	logic [31:0] rsp_rdata_ff;
	logic        good_out_ff;
	logic        aux_out_ff;
	logic        rising_ff;
	logic        regulated_ff;
	logic        flash_store_ff;
	logic [31:0] nxt_rdata;
	logic        code_known;

	wire wr         = ce_i && cmd_valid_i && cmd_write_i;
	wire rd         = ce_i && cmd_valid_i && !cmd_write_i;
	wire wr_op      = wr && (cmd_code_i == pmcrs_pkg::CMD_OPERATION);
	wire wr_clr     = wr && (cmd_code_i == pmcrs_pkg::CMD_CLEAR_FLT);
	wire wr_store   = wr && (cmd_code_i == pmcrs_pkg::CMD_STORE_ALL);
	wire wr_otw     = wr && (cmd_code_i == pmcrs_pkg::CMD_OTW_LIMIT);
	wire wr_tdly    = wr && (cmd_code_i == pmcrs_pkg::CMD_TURN_ON_DELAY);
	wire wr_trise   = wr && (cmd_code_i == pmcrs_pkg::CMD_OUTPUT_RISE_TIME);
	wire wr_afunc   = wr && (cmd_code_i == pmcrs_pkg::CMD_AUX_FUNC);
	wire wr_apol    = wr && (cmd_code_i == pmcrs_pkg::CMD_AUX_POL);
	wire wr_gpol    = wr && (cmd_code_i == pmcrs_pkg::CMD_GOOD_POL);
	wire wr_key     = wr && (cmd_code_i == pmcrs_pkg::CMD_FLASH_KEY);
	wire otw_good   = lin_ok(cmd_wdata_i[15:0], pmcrs_pkg::EXP_M2,
		pmcrs_pkg::OTW_MIN, pmcrs_pkg::OTW_MAX);
	wire tdly_good  = lin_ok(cmd_wdata_i[15:0], pmcrs_pkg::EXP_M1,
		pmcrs_pkg::TURN_ON_DELAY_MIN, pmcrs_pkg::TURN_ON_DELAY_MAX);
	wire trise_good = lin_ok(cmd_wdata_i[15:0], pmcrs_pkg::EXP_M1,
		pmcrs_pkg::OUTPUT_RISE_TIME_MIN, pmcrs_pkg::OUTPUT_RISE_TIME_MAX);
	wire unlocked   = (flash_key_ff == pmcrs_pkg::UNLOCK_KEY);
	wire store_ok   = wr_store && unlocked;
	wire wr_rw_code = wr_op || wr_clr || wr_store || wr_otw || wr_tdly || wr_trise
		|| wr_afunc || wr_apol || wr_gpol || wr_key;
	// Read-only or unknown codes written, and reads of unknown codes
	wire bad_cmd    = (wr && !wr_rw_code) || (rd && !code_known);
	// Out-of-range limit data and a save attempted while locked
	wire bad_data   = (wr_otw && !otw_good) || (wr_tdly && !tdly_good)
		|| (wr_trise && !trise_good) || (wr_store && !unlocked);

	// Configuration registers; an out-of-range limit keeps the old value
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			operation_ff <= pmcrs_pkg::RST_OPERATION;
			otw_limit_ff <= pmcrs_pkg::RST_OTW_LIMIT;
			turn_on_delay_ff <= pmcrs_pkg::RST_TURN_ON_DELAY;
			output_rise_time_ff  <= pmcrs_pkg::RST_OUTPUT_RISE_TIME;
			aux_func_ff  <= pmcrs_pkg::RST_AUX_FUNC;
			aux_pol_ff   <= pmcrs_pkg::RST_AUX_POL;
			good_pol_ff  <= pmcrs_pkg::RST_GOOD_POL;
			flash_key_ff <= pmcrs_pkg::RST_FLASH_KEY;
		end else begin
			if (wr_op)
				operation_ff <= {cmd_wdata_i[7], 7'h00};
			if (wr_otw && otw_good)
				otw_limit_ff <= cmd_wdata_i[15:0];
			if (wr_tdly && tdly_good)
				turn_on_delay_ff <= cmd_wdata_i[15:0];
			if (wr_trise && trise_good)
				output_rise_time_ff <= cmd_wdata_i[15:0];
			if (wr_afunc)
				aux_func_ff <= cmd_wdata_i[7:0];
			if (wr_apol)
				aux_pol_ff <= cmd_wdata_i[7:0];
			if (wr_gpol)
				good_pol_ff <= cmd_wdata_i[7:0];
			// A save consumes the key so the next save needs a fresh unlock
			if (wr_key)
				flash_key_ff <= cmd_wdata_i;
			else if (store_ok)
				flash_key_ff <= pmcrs_pkg::RST_FLASH_KEY;
		end
	end

	// Sticky status; a new event in the clearing cycle survives the clear
	wire [7:0] set_vout  = {vout_ov_fault_i, vout_ov_warn_i, 6'h00};
	wire [7:0] set_iout  = {iout_oc_fault_i, 1'b0, iout_oc_warn_i, 5'h00};
	wire [7:0] set_input = {vin_ov_fault_i, 2'b00, vin_uv_fault_i, 4'h0};
	wire       otw_hit   = (temp_reading_i[10:0] >= otw_limit_ff[10:0]);
	wire [7:0] set_temp  = {ot_fault_i, otw_hit, 6'h00};
	wire [7:0] set_cml   = {bad_cmd, bad_data, 6'h00};
	wire [7:0] keep_mask = wr_clr ? 8'h00 : 8'hff;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_vout_ff  <= 8'h00;
			st_iout_ff  <= 8'h00;
			st_input_ff <= 8'h00;
			st_temp_ff  <= 8'h00;
			st_cml_ff   <= 8'h00;
		end else if (ce_i) begin
			st_vout_ff  <= (st_vout_ff & keep_mask) | set_vout;
			st_iout_ff  <= (st_iout_ff & keep_mask) | set_iout;
			st_input_ff <= (st_input_ff & keep_mask) | set_input;
			st_temp_ff  <= (st_temp_ff & keep_mask) | set_temp;
			st_cml_ff   <= (st_cml_ff & keep_mask) | set_cml;
		end
	end

	// Power good with hysteresis between the two thresholds
	wire pg_rise = (vout_reading_i >= pmcrs_pkg::RST_GOOD_ON);
	wire pg_fall = (vout_reading_i <= pmcrs_pkg::RST_GOOD_OFF);
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pg_ff <= 1'b0;
		else if (ce_i && !pg_ff && pg_rise)
			pg_ff <= 1'b1;
		else if (ce_i && pg_ff && pg_fall)
			pg_ff <= 1'b0;
	end

	// Turn-on sequence: delay then rise, counted in 0.5 ms steps (one LSB at exponent -1)
	// A shorter step is for simulation only; a build keeps the package value
	wire run_req  = operation_ff[7] && input_valid_i;
	wire step_end = (step_cnt_ff == ($bits(step_cnt_ff))'(STEP_CYC - 1));
	wire dly_done = step_end && (step_num_ff >= turn_on_delay_ff[10:0]);
	wire rise_done = step_end && (step_num_ff >= output_rise_time_ff[10:0]);

	always_comb begin
		nxt_seq = seq_ff;
		unique case (seq_ff)
			SEQ_OFF:   if (run_req) nxt_seq = SEQ_DELAY;
			SEQ_DELAY: if (!run_req) nxt_seq = SEQ_OFF;
				else if (dly_done) nxt_seq = SEQ_RISE;
			SEQ_RISE:  if (!run_req) nxt_seq = SEQ_OFF;
				else if (rise_done) nxt_seq = SEQ_ON;
			SEQ_ON:    if (!run_req) nxt_seq = SEQ_OFF;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seq_ff      <= SEQ_OFF;
			step_cnt_ff <= '0;
			step_num_ff <= 11'h000;
		end else if (ce_i) begin
			seq_ff <= nxt_seq;
			if (nxt_seq != seq_ff || seq_ff == SEQ_OFF || seq_ff == SEQ_ON) begin
				step_cnt_ff <= '0;
				step_num_ff <= 11'h001;
			end else if (step_end) begin
				step_cnt_ff <= '0;
				step_num_ff <= step_num_ff + 11'h001;
			end else begin
				step_cnt_ff <= step_cnt_ff + 1'b1;
			end
		end
	end

	// Summary word built from the sticky bytes and live state
	wire        unit_off = (seq_ff != SEQ_ON);
	wire [15:0] summary  = {|st_vout_ff, |st_iout_ff, |st_input_ff, 1'b0, !pg_ff, 3'b000,
		1'b0, unit_off, st_vout_ff[pmcrs_pkg::BIT_FAULT], st_iout_ff[pmcrs_pkg::BIT_FAULT],
		st_input_ff[pmcrs_pkg::BIT_IN_UV], |st_temp_ff, |st_cml_ff, 1'b0};

	// Read selection; unknown codes answer zero
	always_comb begin
		nxt_rdata  = 32'h0000_0000;
		code_known = 1'b1;
		case (cmd_code_i)
			pmcrs_pkg::CMD_OPERATION:  nxt_rdata = {24'h0, operation_ff};
			pmcrs_pkg::CMD_OTW_LIMIT:  nxt_rdata = {16'h0, otw_limit_ff};
			pmcrs_pkg::CMD_VIN_OV:     nxt_rdata = {16'h0, pmcrs_pkg::RST_VIN_OV};
			pmcrs_pkg::CMD_GOOD_ON:    nxt_rdata = {16'h0, pmcrs_pkg::RST_GOOD_ON};
			pmcrs_pkg::CMD_GOOD_OFF:   nxt_rdata = {16'h0, pmcrs_pkg::RST_GOOD_OFF};
			pmcrs_pkg::CMD_TURN_ON_DELAY:  nxt_rdata = {16'h0, turn_on_delay_ff};
			pmcrs_pkg::CMD_OUTPUT_RISE_TIME:   nxt_rdata = {16'h0, output_rise_time_ff};
			pmcrs_pkg::CMD_STAT_SUM:   nxt_rdata = {16'h0, summary};
			pmcrs_pkg::CMD_STAT_VOUT:  nxt_rdata = {24'h0, st_vout_ff};
			pmcrs_pkg::CMD_STAT_IOUT:  nxt_rdata = {24'h0, st_iout_ff};
			pmcrs_pkg::CMD_STAT_INPUT: nxt_rdata = {24'h0, st_input_ff};
			pmcrs_pkg::CMD_STAT_TEMP:  nxt_rdata = {24'h0, st_temp_ff};
			pmcrs_pkg::CMD_STAT_COMM:  nxt_rdata = {24'h0, st_cml_ff};
			pmcrs_pkg::CMD_READ_VIN:   nxt_rdata = {16'h0, vin_reading_i};
			pmcrs_pkg::CMD_READ_VOUT:  nxt_rdata = {16'h0, vout_reading_i};
			pmcrs_pkg::CMD_OUTPUT_CURRENT_READING:  nxt_rdata = {16'h0, iout_reading_i};
			pmcrs_pkg::CMD_READ_TEMP:  nxt_rdata = {16'h0, temp_reading_i};
			pmcrs_pkg::CMD_PROTO_REV:  nxt_rdata = {24'h0, PROTO_REV};
			pmcrs_pkg::CMD_AUX_FUNC:   nxt_rdata = {24'h0, aux_func_ff};
			pmcrs_pkg::CMD_AUX_POL:    nxt_rdata = {24'h0, aux_pol_ff};
			pmcrs_pkg::CMD_GOOD_POL:   nxt_rdata = {24'h0, good_pol_ff};
			pmcrs_pkg::CMD_FLASH_KEY:  nxt_rdata = flash_key_ff;
			default:                   code_known = 1'b0;
		endcase
	end

	// Aux pin: function 0 shows any summary bit set, power good low and unit off included, otherwise shows the unit running
	wire aux_src = (aux_func_ff == 8'h00) ? (|summary) : !unit_off;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rsp_valid_ff   <= 1'b0;
			rsp_rdata_ff   <= 32'h0000_0000;
			good_out_ff    <= 1'b0;
			aux_out_ff     <= 1'b0;
			rising_ff      <= 1'b0;
			regulated_ff   <= 1'b0;
			flash_store_ff <= 1'b0;
		end else if (ce_i) begin
			rsp_valid_ff   <= cmd_valid_i;
			if (rd)
				rsp_rdata_ff <= nxt_rdata;
			good_out_ff    <= good_pol_ff[0] ? pg_ff : !pg_ff;
			aux_out_ff     <= aux_src ^ aux_pol_ff[0];
			rising_ff      <= (nxt_seq == SEQ_RISE);
			regulated_ff   <= (nxt_seq == SEQ_ON);
			flash_store_ff <= store_ok;
		end
	end

	assign rsp_valid_o            = rsp_valid_ff;
	assign rsp_rdata_o            = rsp_rdata_ff;
	assign good_output_signal_o   = good_out_ff;
	assign aux_configurable_pin_o = aux_out_ff;
	assign output_rising_o        = rising_ff;
	assign output_regulated_o     = regulated_ff;
	assign flash_store_o          = flash_store_ff;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	a_otw_range_held: assert property (otw_limit_ff[10:0] >= pmcrs_pkg::OTW_MIN
		&& otw_limit_ff[10:0] <= pmcrs_pkg::OTW_MAX) else $error("warning limit out of range");
	a_ro_write_flag: assert property (wr && cmd_code_i == pmcrs_pkg::CMD_VIN_OV
		|=> st_cml_ff[pmcrs_pkg::BIT_CML_CMD]) else $error("read-only write not flagged");
	a_pg_rise_set: assert property (ce_i && !pg_ff && pg_rise |=> pg_ff ##1
		(good_out_ff == $past(good_pol_ff[0]))) else $error("power good missed");
	a_pg_fall_clear: assert property (ce_i && pg_ff && pg_fall |=> !pg_ff)
		else $error("power good not negated");
	a_store_locked_drop: assert property (wr_store && !unlocked |=> !flash_store_o
		&& st_cml_ff[pmcrs_pkg::BIT_CML_DATA]) else $error("locked save accepted");
	a_store_unlock_go: assert property (wr_store && unlocked |=> flash_store_o
		##1 !flash_store_o) else $error("unlocked save lost");
	a_tdly_range_held: assert property (turn_on_delay_ff[10:0] >= pmcrs_pkg::TURN_ON_DELAY_MIN
		&& turn_on_delay_ff[10:0] <= pmcrs_pkg::TURN_ON_DELAY_MAX) else $error("delay out of range");
	a_trise_range_held: assert property (output_rise_time_ff[10:0] >= pmcrs_pkg::OUTPUT_RISE_TIME_MIN
		&& output_rise_time_ff[10:0] <= pmcrs_pkg::OUTPUT_RISE_TIME_MAX) else $error("rise out of range");
	a_sum_pg_bit: assert property (rd && cmd_code_i == pmcrs_pkg::CMD_STAT_SUM
		|=> rsp_valid_o && rsp_rdata_o[11] == !$past(pg_ff)) else $error("summary wrong");
	a_read_vin_word: assert property (rd && cmd_code_i == pmcrs_pkg::CMD_READ_VIN
		|=> rsp_rdata_o == {16'h0, $past(vin_reading_i)}) else $error("input reading wrong");
	a_cmd_answered: assert property (ce_i && cmd_valid_i |=> rsp_valid_o)
		else $error("command not answered");
	a_unknown_rd_flag: assert property (rd && !code_known |=> rsp_rdata_o == 32'h0
		&& st_cml_ff[pmcrs_pkg::BIT_CML_CMD]) else $error("unknown read not flagged");
	a_set_beats_clear: assert property (ce_i && wr_clr && ot_fault_i
		|=> st_temp_ff[pmcrs_pkg::BIT_FAULT]) else $error("clear hid a new fault");
	a_seq_drop_off: assert property (ce_i && !run_req |=> seq_ff == SEQ_OFF)
		else $error("sequence kept running");
	a_phase_outputs: assert property (output_rising_o == (seq_ff == SEQ_RISE)
		&& output_regulated_o == (seq_ff == SEQ_ON)) else $error("phase outputs wrong");
	a_key_consumed: assert property (store_ok |=> !unlocked)
		else $error("key survived a save");

	c_pg_up:     cover property (!pg_ff ##1 pg_ff);
	c_seq_on:    cover property (seq_ff == SEQ_RISE ##1 seq_ff == SEQ_ON);
	c_store:     cover property (flash_store_o);
	c_ro_write:  cover property (wr && !wr_rw_code);
	c_unlock:    cover property (wr_key && cmd_wdata_i == pmcrs_pkg::UNLOCK_KEY);
endmodule : pmcrs_top
`default_nettype wire
